// [lcdmp_map.vh]
// Purpose: constants for the lcd driver processor port
// Assumes: 8-bit data, 80 columns, 4 pages
// Notes:   instruction codes are the decoded 8-bit command values
`ifndef LCDMP_MAP_VH
`define LCDMP_MAP_VH
`define LCDMP_COL_LIMIT      7'h50
`define LCDMP_MEM_DEPTH      10'h200
`define LCDMP_PAGE_RESET     2'h3
`define LCDMP_CMD_DISP_OFF   8'hAE
`define LCDMP_CMD_DISP_ON    8'hAF
`define LCDMP_CMD_ADC0       8'hA0
`define LCDMP_CMD_ADC1       8'hA1
`define LCDMP_CMD_STAT_OFF   8'hA4
`define LCDMP_CMD_STAT_ON    8'hA5
`define LCDMP_CMD_DUTY0      8'hA8
`define LCDMP_CMD_DUTY1      8'hA9
`define LCDMP_CMD_RMW        8'hE0
`define LCDMP_CMD_END        8'hEE
`define LCDMP_CMD_RESET      8'hE2
`define LCDMP_PAGE_MASK      8'hFC
`define LCDMP_PAGE_CODE      8'hB8
`define LCDMP_START_MASK     8'hE0
`define LCDMP_START_CODE     8'hC0
`define LCDMP_COLSET_MASK    8'h80
`define LCDMP_COLSET_CODE    8'h00
`define LCDMP_RESET_CYCLES   4'h4
`endif

// [lcdmp_port.v]
// Purpose: processor-side port of a bit-map lcd driver with power save
// Assumes: all inputs synchronous to refClk; strobes held for several clocks
// Notes:   one access is taken on each strobe's rising activity edge
//          writes and commands queue in a two-entry buffer while busy
//          a data read answers with the byte held from the previous data read or data write
`timescale 1ns/1ps
`include "lcdmp_map.vh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - power save holds segment and common high
// - power save stops clock, oscillator pin floats
// - power save keeps memory and mode settings
// - display-on or static-off leaves power save
// - reset pin after reset picks bus style
// - chip select high ignores normal accesses
// - reset instruction accepted in any state
// - select line and direction pick four accesses
// - data write committed on next write
// - first read after address set is stale
// - display-off plus static-on enters power save
// - column increments, stops at limit, page kept
module lcdmp_port #(
	parameter COLS = 80,
	parameter DW   = 8
) (
	input  wire          ref_clk,
	input  wire          rst,
	input  wire          chipSelHigh,
	input  wire          register_select,
	input  wire          enableRdN,
	input  wire          rwWrN,
	input  wire          resetPin,
	input  wire [DW-1:0] dataIn,
	output wire [DW-1:0] dataOut,
	output wire          dataOe_n,
	input  wire          frame_clock_input,
	output wire          frameClkGated,
	output wire          oscillator_output_pin_oe_n,
	output reg           powerSave_reg,
	output wire          driveAllHigh,
	output reg           displayOn_reg,
	output reg           staticOn_reg,
	output reg           adc_reg,
	output reg           duty_reg,
	output reg  [4:0]    startLine_reg,
	output reg           mode68_reg,
	input  wire [6:0]    scanCol,
	input  wire [1:0]    scanPage,
	output reg  [DW-1:0] scanData_reg
);

reg  [DW-1:0] mem [0:`LCDMP_MEM_DEPTH-1];
reg  [6:0]    col_reg;
reg  [6:0]    rmwCol_reg;
reg           rmw_reg;
reg  [1:0]    page_reg;
reg  [DW-1:0] holder_reg;
reg  [8:0]    holdAddr_reg;
reg           holdValid_reg;
reg  [DW-1:0] rdHolder_reg;
reg  [DW-1:0] rdOut_reg;
reg           strobe_reg;
reg  [3:0]    resetCnt_reg;
reg           resetSample_reg;
// two-entry skid buffer on incoming writes
reg  [DW:0]   buf0_reg;
reg  [DW:0]   buf1_reg;
reg  [1:0]    bufCnt_reg;

//////////////////////////////////////////////////////////////////////////////
// access decode
wire rdAct  = mode68_reg ? (~enableRdN & rwWrN) : ~enableRdN;
wire wrAct  = mode68_reg ? (~enableRdN & ~rwWrN) : ~rwWrN;
wire strobe = (rdAct | wrAct) & ~chipSelHigh;
wire take   = strobe & ~strobe_reg;
wire isRead = rdAct;
wire isCmd  = ~register_select;
wire cmdWr  = take & ~isRead & isCmd;
wire datWr  = take & ~isRead & ~isCmd;
wire datRd  = take & isRead & ~isCmd;
wire [8:0] addr  = {page_reg, col_reg};
wire [6:0] colInc = (col_reg < `LCDMP_COL_LIMIT) ? col_reg + 7'h01 : col_reg;
wire busyFlag = resetCnt_reg != 4'h0;

// buffer: push on data/command writes, pop one entry per clock
wire bufInReady  = bufCnt_reg != 2'h2;
wire push        = cmdWr | datWr;
wire bufOutValid = bufCnt_reg != 2'h0;
wire bufOutReady = ~busyFlag;                              // executor stalls while busy
wire pop         = bufOutValid & bufOutReady;
wire popCmd      = pop & buf0_reg[DW];
wire popDat      = pop & ~buf0_reg[DW];
wire [DW-1:0] popVal = buf0_reg[DW-1:0];

//////////////////////////////////////////////////////////////////////////////
// instruction decode of the word leaving the buffer; codes never overlap
wire cmdReset   = popCmd & (popVal == `LCDMP_CMD_RESET);

// display and power-save pair
wire cmdDispOn  = popCmd & (popVal == `LCDMP_CMD_DISP_ON);
wire cmdDispOff = popCmd & (popVal == `LCDMP_CMD_DISP_OFF);
wire cmdStatOff = popCmd & (popVal == `LCDMP_CMD_STAT_OFF);
wire cmdStatOn  = popCmd & (popVal == `LCDMP_CMD_STAT_ON);

// mode settings
wire cmdAdc     = popCmd & ((popVal == `LCDMP_CMD_ADC0) | (popVal == `LCDMP_CMD_ADC1));
wire cmdDuty    = popCmd & ((popVal == `LCDMP_CMD_DUTY0) | (popVal == `LCDMP_CMD_DUTY1));
wire cmdStart   = popCmd & ((popVal & `LCDMP_START_MASK) == `LCDMP_START_CODE);

// addressing
wire cmdRmw     = popCmd & (popVal == `LCDMP_CMD_RMW);
wire cmdEnd     = popCmd & (popVal == `LCDMP_CMD_END);
wire cmdPage    = popCmd & ((popVal & `LCDMP_PAGE_MASK) == `LCDMP_PAGE_CODE);
wire cmdColSet  = popCmd & ((popVal & `LCDMP_COLSET_MASK) == `LCDMP_COLSET_CODE);

assign dataOe_n = ~(rdAct & ~chipSelHigh);
wire [DW-1:0] statusByte = {busyFlag, adc_reg, ~displayOn_reg, busyFlag, 4'h0};
assign dataOut  = rdOut_reg;
assign driveAllHigh = powerSave_reg;
assign frameClkGated = frame_clock_input & ~powerSave_reg;
assign oscillator_output_pin_oe_n = powerSave_reg;

//////////////////////////////////////////////////////////////////////////////
// buffer and strobe edge
always @(posedge ref_clk) begin
	if (rst) begin
		strobe_reg <= 1'b0;
		bufCnt_reg <= 2'h0;
		buf0_reg   <= {(DW+1){1'b0}};
		buf1_reg   <= {(DW+1){1'b0}};
	end else begin
		strobe_reg <= strobe;
		if (push && bufInReady) begin
			if (pop) begin
				if (bufCnt_reg == 2'h1)
					buf0_reg <= {isCmd, dataIn};
				else begin
					buf0_reg <= buf1_reg;
					buf1_reg <= {isCmd, dataIn};
				end
			end else if (bufCnt_reg == 2'h0)
				buf0_reg <= {isCmd, dataIn};
			else
				buf1_reg <= {isCmd, dataIn};
			if (!pop)
				bufCnt_reg <= bufCnt_reg + 2'h1;
		end else if (pop) begin
			buf0_reg   <= buf1_reg;
			bufCnt_reg <= bufCnt_reg - 2'h1;
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// busy counter and bus-style sampling after either reset
// busy also covers the reset instruction, so queued words wait behind it
always @(posedge ref_clk) begin
	if (rst) begin
		resetCnt_reg    <= `LCDMP_RESET_CYCLES;
		resetSample_reg <= 1'b1;
		mode68_reg      <= 1'b1;
	end else begin
		if (cmdReset) begin
			resetCnt_reg    <= `LCDMP_RESET_CYCLES;
			resetSample_reg <= 1'b1;
		end else begin
			resetSample_reg <= 1'b0;
			if (busyFlag)
				resetCnt_reg <= resetCnt_reg - 4'h1;
		end
		if (resetSample_reg)
			mode68_reg <= resetPin;
	end
end

//////////////////////////////////////////////////////////////////////////////
// display and power-save flags
// power save touches neither memory nor mode settings
always @(posedge ref_clk) begin
	if (rst) begin
		displayOn_reg <= 1'b0;
		staticOn_reg  <= 1'b0;
		powerSave_reg <= 1'b0;
	end else begin
		if (cmdDispOn) begin
			displayOn_reg <= 1'b1;
			powerSave_reg <= 1'b0;
		end
		if (cmdDispOff) begin
			displayOn_reg <= 1'b0;
			powerSave_reg <= staticOn_reg;
		end
		if (cmdStatOff) begin
			staticOn_reg  <= 1'b0;
			powerSave_reg <= 1'b0;
		end
		if (cmdStatOn) begin
			staticOn_reg  <= 1'b1;
			powerSave_reg <= ~displayOn_reg;
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// operating mode settings; only instructions change them
always @(posedge ref_clk) begin
	if (rst) begin
		adc_reg       <= 1'b0;
		duty_reg      <= 1'b0;
		startLine_reg <= 5'h00;
	end else begin
		if (cmdAdc)
			adc_reg <= popVal[0];
		if (cmdDuty)
			duty_reg <= popVal[0];
		if (cmdStart)
			startLine_reg <= popVal[4:0];
		if (cmdReset)
			startLine_reg <= 5'h00;
	end
end

//////////////////////////////////////////////////////////////////////////////
// page register and read-modify-write bookkeeping
always @(posedge ref_clk) begin
	if (rst) begin
		page_reg   <= `LCDMP_PAGE_RESET;
		rmw_reg    <= 1'b0;
		rmwCol_reg <= 7'h00;
	end else begin
		if (cmdReset)
			page_reg <= `LCDMP_PAGE_RESET;
		if (cmdPage)
			page_reg <= popVal[1:0];
		if (cmdRmw) begin
			rmw_reg    <= 1'b1;
			rmwCol_reg <= col_reg;
		end
		if (cmdEnd)
			rmw_reg <= 1'b0;
	end
end

//////////////////////////////////////////////////////////////////////////////
// column counter and the write and read holders
// a write pop and a read take never meet while the cycle time is kept
always @(posedge ref_clk) begin
	if (rst) begin
		col_reg       <= 7'h00;
		holder_reg    <= {DW{1'b0}};
		holdAddr_reg  <= 9'h000;
		holdValid_reg <= 1'b0;
		rdHolder_reg  <= {DW{1'b0}};
	end else begin
		if (popDat) begin
			holder_reg    <= popVal;
			holdAddr_reg  <= addr;
			holdValid_reg <= 1'b1;
			rdHolder_reg  <= popVal;
			col_reg       <= colInc;
		end
		if (datRd) begin
			rdHolder_reg <= mem[addr];
			if (!rmw_reg)
				col_reg <= colInc;
		end
		if (cmdEnd)
			col_reg <= rmwCol_reg;
		if (cmdColSet && !rmw_reg)
			col_reg <= popVal[6:0];
	end
end

//////////////////////////////////////////////////////////////////////////////
// display memory: holder commit port and display scan port
// words are addressed as page then column, columns past the limit reached only through a column set
wire          memWe    = popDat & holdValid_reg;
wire [8:0]    memWAddr = holdAddr_reg;
wire [DW-1:0] memWData = holder_reg;

always @(posedge ref_clk) begin
	if (memWe)
		mem[memWAddr] <= memWData;
	scanData_reg <= mem[{scanPage, scanCol}];
end

//////////////////////////////////////////////////////////////////////////////
// read byte latched at the take edge, so a data read shows the older byte
always @(posedge ref_clk) begin
	if (rst)
		rdOut_reg <= {DW{1'b0}};
	else if (take && isRead) begin
		if (isCmd)
			rdOut_reg <= statusByte;
		else
			rdOut_reg <= rdHolder_reg;
	end
end

endmodule // lcdmp_port

// [lcdmp_port_asserts.sv]
// Purpose: port checks for lcdmp_port
// Assumes: one clock, sync reset
// Notes: bound after the module
`timescale 1ns/1ps
module lcdmp_chk (input wire ref_clk, rst, chipSelHigh, enableRdN, rwWrN, resetPin,
	dataOe_n, frame_clock_input, frameClkGated, oscillator_output_pin_oe_n,
	powerSave_reg, driveAllHigh, displayOn_reg, staticOn_reg, adc_reg, mode68_reg);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence desel_s; chipSelHigh [*8]; endsequence
	sequence save_s; !displayOn_reg && staticOn_reg; endsequence
	drive_high_a: assert property (powerSave_reg |-> driveAllHigh)
		else $error("drive");
	osc_float_a: assert property (powerSave_reg |-> oscillator_output_pin_oe_n)
		else $error("osc");
	clk_gate_a: assert property (frameClkGated == (frame_clock_input && !powerSave_reg))
		else $error("clk");
	save_on_a: assert property (save_s |-> ##[0:1] powerSave_reg)
		else $error("save on");
	save_off_a: assert property (!staticOn_reg || displayOn_reg |-> ##[0:1] !powerSave_reg)
		else $error("save off");
	desel_quiet_a: assert property (desel_s |-> $stable(adc_reg) && $stable(displayOn_reg))
		else $error("desel");
	bus_style_a: assert property ($fell(rst) ##1 1 |-> mode68_reg == resetPin)
		else $error("style");
	read_drive_a: assert property (!dataOe_n == (!chipSelHigh && !enableRdN && (rwWrN || !mode68_reg)))
		else $error("oe");
endmodule // lcdmp_chk
bind lcdmp_port lcdmp_chk chk_u (.*);

// [lcdmp_mpu_model.sv]
// Purpose: processor bus master model
// Assumes: timing counted in ref_clk cycles
// Notes: idle data lines show inverted last value
`timescale 1ns/1ps
module lcdmp_mpu_model #(parameter CYC = 25, PW = 5) (
	input wire ref_clk, mode68,
	input wire [7:0] dataOut,
	output logic chipSelHigh = 1'h1, register_select = 1'h0, enableRdN = 1'h1, rwWrN = 1'h1,
	output logic [7:0] dataIn = 8'h00);
	task automatic acc(input logic cs, rs, rd, input logic [7:0] wd, output logic [7:0] q);
		@(posedge ref_clk);
		chipSelHigh <= cs;
		register_select <= rs;
		dataIn <= wd;
		enableRdN <= !(mode68 || rd);
		rwWrN <= rd;
		repeat (PW) @(posedge ref_clk);
		q = dataOut;
		chipSelHigh <= 1'h1;
		enableRdN <= 1'h1;
		rwWrN <= 1'h1;
		dataIn <= ~wd;
		repeat (CYC - PW - 1) @(posedge ref_clk);
	endtask
endmodule // lcdmp_mpu_model

// [lcd_driver_mpu_port_power_save_tb_top.sv]
// Purpose: self-checking bench for lcdmp_port
// Assumes: 25 MHz ref_clk
// Notes: reference keeps written bytes per column
`timescale 1ns/1ps
`include "lcdmp_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failCount++; \
	$display("BAD %0t %h %h", $time, g, e); end end
module lcd_driver_mpu_port_power_save_tb_top;
	logic ref_clk = 0, rst = 1, resetPin = 1, fclk = 0;
	wire chipSelHigh, register_select, enableRdN, rwWrN, powerSave_reg, mode68_reg;
	wire [7:0] dataIn, dataOut;
	logic [7:0] q, d, mem [80];
	logic [1:0] pg = 2'h0;
	logic [4:0] sl;
	wire [4:0] startLine;
	wire [7:0] scanData;
	int compares, failCount, cyc;
	lcdmp_port dut_u (.ref_clk, .rst, .chipSelHigh, .register_select, .enableRdN, .rwWrN,
		.resetPin, .dataIn, .dataOut, .dataOe_n(), .frame_clock_input(fclk), .frameClkGated(),
		.oscillator_output_pin_oe_n(), .powerSave_reg, .driveAllHigh(), .displayOn_reg(),
		.staticOn_reg(), .adc_reg(), .duty_reg(), .startLine_reg(startLine), .mode68_reg,
		.scanCol(7'h4D), .scanPage(pg), .scanData_reg(scanData));
	lcdmp_mpu_model mpu_u (.ref_clk, .mode68(mode68_reg), .dataOut, .chipSelHigh,
		.register_select, .enableRdN, .rwWrN, .dataIn);
	initial forever #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) fclk <= ~fclk;
	task automatic give_verdict;
		$display("compares %0d failCount %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c);
		mpu_u.acc(0, 0, 0, c, q);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failCount++;
			give_verdict;
		end
	end
	initial begin
		d = 8'($urandom(57941));
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		for (int m = 1; m >= 0; m--) begin
			resetPin <= m[0];
			cmd(`LCDMP_CMD_RESET);
			`CHK(mode68_reg, m[0])
			`CHK(startLine, 5'h00)
			d = 8'($urandom);
			sl = d[6:2];
			pg <= d[1:0];
			cmd(`LCDMP_PAGE_CODE | {6'h00, d[1:0]});
			cmd(`LCDMP_START_CODE | {3'h0, sl});
			cmd(8'h4C);
			// fifth write lands at the stopped column and is never read
			for (int i = 76; i < 81; i++) begin
				d = 8'($urandom);
				mpu_u.acc(0, 1, 0, d, q);
				if (i < 80) mem[i] = d;
			end
			cmd(`LCDMP_CMD_DISP_OFF);
			cmd(`LCDMP_CMD_STAT_ON);
			`CHK(powerSave_reg, 1'h1)
			mpu_u.acc(1, 0, 0, `LCDMP_CMD_ADC1, q);
			cmd(m ? `LCDMP_CMD_DISP_ON : `LCDMP_CMD_STAT_OFF);
			`CHK(powerSave_reg, 1'h0)
			`CHK(startLine, sl)
			cmd(8'h4C);
			for (int i = 75; i < 80; i++) begin
				mpu_u.acc(0, 1, 1, 8'h00, q);
				if (i > 75) `CHK(q, mem[i])
			end
			`CHK(scanData, mem[77])
			mpu_u.acc(0, 0, 1, 8'h00, q);
			`CHK(q, {2'h0, !m[0], 5'h00})
		end
		give_verdict;
	end
endmodule // lcd_driver_mpu_port_power_save_tb_top
